// ---- src/monitor_flash_security_gate.sv ----
// flash read-protection gate checked at monitor mode entry
`default_nettype none
module monitor_flash_security_gate #(
  parameter int BIT_CYCLES = sec_gate_pkg::BIT_CYCLES
) (
  // clock and power-on reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // any other reset, one-cycle pulse
  input wire logic sys_reset_i,
  // monitor serial pin
  input wire logic monitor_serial_pin_i,
  output logic monitor_serial_pin_o,
  output logic monitor_serial_pin_oe_o,
  // security byte storage
  input wire logic prog_we_i,
  input wire logic [2:0] prog_idx_i,
  input wire logic [7:0] prog_data_i,
  input wire logic mass_erase_i,
  // cpu flash access
  input wire logic cpu_rd_i,
  input wire logic cpu_fetch_i,
  input wire logic [7:0] flash_rdata_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic illegal_addr_reset_o,
  // status
  output logic [7:0] status_byte_o,
  output logic unlocked_o,
  output logic monitor_ready_o
);
  localparam int BREAK_CYCLES = BIT_CYCLES * sec_gate_pkg::BREAK_BITS;
  localparam int BCW = $clog2(BREAK_CYCLES) + 1;

  if (BIT_CYCLES < 4) begin : g_chk
    $error("BIT_CYCLES too small");
  end

  // byte index and program index are three bits wide
  if (sec_gate_pkg::SEC_BYTES != 8) begin : g_chk_bytes
    $error("SEC_BYTES must be 8");
  end

  rx_byte_if rxb ();

  monitor_byte_rx #(.BIT_CYCLES(BIT_CYCLES)) u_rx (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .serial_i(monitor_serial_pin_i),
    .rx(rxb)
  );

  sec_gate_pkg::gate_state_e state;
  logic [7:0] sec_mem [sec_gate_pkg::SEC_BYTES];
  logic [2:0] byte_idx;
  logic match;
  logic unlocked;
  logic [BCW-1:0] break_cnt;
  logic byte_ok;
  logic code_byte;
  logic last_byte;
  logic break_done;

  assign byte_ok = (rxb.data == sec_mem[byte_idx]);
  // a reset cycle drops any byte that lands in it
  assign code_byte = rxb.valid && (state == sec_gate_pkg::ST_WAIT_CODE) && !sys_reset_i;
  assign last_byte = code_byte && (byte_idx == 3'h7);
  assign break_done = (state == sec_gate_pkg::ST_SEND_BREAK) && (break_cnt == '0);

  // ****************************************
  // security byte storage
  // ****************************************
  // flops stand in for the flash cells; erase wins over a program write
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < sec_gate_pkg::SEC_BYTES; i++) begin
        sec_mem[i] <= sec_gate_pkg::SEC_RESET_VALUE;
      end
    end else if (mass_erase_i) begin
      for (int i = 0; i < sec_gate_pkg::SEC_BYTES; i++) begin
        sec_mem[i] <= sec_gate_pkg::SEC_ERASED;
      end
    end else if (prog_we_i) begin
      sec_mem[prog_idx_i] <= prog_data_i;
    end
  end

  // ****************************************
  // entry sequence
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= sec_gate_pkg::ST_WAIT_CODE;
    end else if (sys_reset_i) begin
      // unlock survives; a locked part must enter the code again
      state <= unlocked ? sec_gate_pkg::ST_READY : sec_gate_pkg::ST_WAIT_CODE;
    end else begin
      case (state)
        sec_gate_pkg::ST_WAIT_CODE: begin
          if (last_byte) begin
            state <= sec_gate_pkg::ST_SEND_BREAK;
          end
        end
        sec_gate_pkg::ST_SEND_BREAK: begin
          if (break_done) begin
            state <= sec_gate_pkg::ST_READY;
          end
        end
        sec_gate_pkg::ST_READY: begin
          state <= sec_gate_pkg::ST_READY;
        end
        default: begin
          state <= sec_gate_pkg::ST_WAIT_CODE;
        end
      endcase
    end
  end

  // ****************************************
  // code byte count and compare
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      byte_idx <= 3'h0;
      match <= 1'b1;
    end else if (sys_reset_i) begin
      byte_idx <= 3'h0;
      match <= 1'b1;
    end else if (code_byte) begin
      byte_idx <= byte_idx + 3'h1;
      match <= match & byte_ok;
    end
  end

  // ****************************************
  // unlock flag
  // ****************************************
  // only power-on reset clears it
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      unlocked <= 1'b0;
    end else if (last_byte) begin
      unlocked <= match & byte_ok;
    end
  end

  // ****************************************
  // break timer
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      break_cnt <= '0;
    end else if (sys_reset_i) begin
      break_cnt <= '0;
    end else if (last_byte) begin
      break_cnt <= BCW'(BREAK_CYCLES - 1);
    end else if ((state == sec_gate_pkg::ST_SEND_BREAK) && (break_cnt != '0)) begin
      break_cnt <= break_cnt - 1'b1;
    end
  end

  // ****************************************
  // pin drive
  // ****************************************
  // pin is released outside the break; the external pullup holds it high
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      monitor_serial_pin_o <= 1'b1;
      monitor_serial_pin_oe_o <= 1'b0;
    end else begin
      monitor_serial_pin_o <= 1'b0;
      monitor_serial_pin_oe_o <= (state == sec_gate_pkg::ST_SEND_BREAK) && !sys_reset_i;
    end
  end

  // ****************************************
  // flash access gating
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
      rd_valid_o <= 1'b0;
      illegal_addr_reset_o <= 1'b0;
    end else begin
      rd_valid_o <= cpu_rd_i;
      if (cpu_rd_i) begin
        rd_data_o <= unlocked ? flash_rdata_i : sec_gate_pkg::INVALID_READ;
      end
      illegal_addr_reset_o <= cpu_fetch_i && !unlocked;
    end
  end

  // ****************************************
  // status
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      status_byte_o <= 8'h00;
      unlocked_o <= 1'b0;
      monitor_ready_o <= 1'b0;
    end else begin
      status_byte_o <= 8'h00;
      status_byte_o[sec_gate_pkg::STATUS_UNLOCK_BIT] <= unlocked;
      unlocked_o <= unlocked;
      monitor_ready_o <= (state == sec_gate_pkg::ST_READY);
    end
  end
endmodule : monitor_flash_security_gate
`default_nettype wire

// ---- src/sec_gate_pkg.sv ----
// constants shared by the monitor flash security gate
`default_nettype none
package sec_gate_pkg;
  // serial timing: one bit is 256 bus clocks
  localparam int BIT_CYCLES = 256;
  localparam int BREAK_BITS = 10;
  localparam int BREAK_CYCLES = BIT_CYCLES * BREAK_BITS;
  // security code
  localparam int SEC_BYTES = 8;
  localparam logic [15:0] SEC_FIRST_ADDR = 16'hfff6;
  localparam logic [15:0] SEC_LAST_ADDR = 16'hfffd;
  localparam logic [7:0] SEC_ERASED = 8'hff;
  localparam logic [7:0] SEC_RESET_VALUE = 8'hff;
  // status byte at ram 0x40, bit 6 set when unlocked
  localparam logic [7:0] STATUS_RAM_ADDR = 8'h40;
  localparam int STATUS_UNLOCK_BIT = 6;
  localparam logic [7:0] INVALID_READ = 8'h00;
  typedef enum logic [2:0] {
    ST_WAIT_CODE = 3'b001,
    ST_SEND_BREAK = 3'b010,
    ST_READY = 3'b100
  } gate_state_e;
endpackage : sec_gate_pkg
`default_nettype wire

// ---- src/rx_byte_if.sv ----
// received-byte carrier between the serial receiver and the gate
`default_nettype none
interface rx_byte_if;
  logic valid;
  logic [7:0] data;
  modport src (output valid, output data);
  modport snk (input valid, input data);
endinterface : rx_byte_if
`default_nettype wire

// ---- src/monitor_byte_rx.sv ----
// nrz byte receiver for the monitor serial pin
`default_nettype none
module monitor_byte_rx #(
  parameter int BIT_CYCLES = sec_gate_pkg::BIT_CYCLES
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // serial line
  input wire logic serial_i,
  // received bytes
  rx_byte_if.src rx
);
  localparam int CW = $clog2(BIT_CYCLES) + 1;

  if (BIT_CYCLES < 4) begin : g_chk
    $error("BIT_CYCLES too small");
  end

  logic sync1;
  logic sync2;
  logic busy;
  logic [CW-1:0] cnt;
  logic [3:0] bitn;
  logic [7:0] shreg;

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
    end else begin
      sync1 <= serial_i;
      sync2 <= sync1;
    end
  end

  // ****************************************
  // bit sampling, mid-bit
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy <= 1'b0;
      cnt <= '0;
      bitn <= 4'h0;
      shreg <= 8'h00;
      rx.valid <= 1'b0;
      rx.data <= 8'h00;
    end else begin
      rx.valid <= 1'b0;
      if (!busy) begin
        if (!sync2) begin
          busy <= 1'b1;
          cnt <= CW'(BIT_CYCLES / 2);
          bitn <= 4'h0;
        end
      end else if (cnt != '0) begin
        cnt <= cnt - 1'b1;
      end else begin
        cnt <= CW'(BIT_CYCLES - 1);
        bitn <= bitn + 4'h1;
        if (bitn == 4'h0 && sync2) begin
          busy <= 1'b0; // glitch, not a start bit
        end else if (bitn == 4'h9) begin
          busy <= 1'b0;
          rx.valid <= 1'b1;
          rx.data <= shreg;
        end else if (bitn != 4'h0) begin
          shreg <= {sync2, shreg[7:1]}; // lsb first
        end
      end
    end
  end
endmodule : monitor_byte_rx
`default_nettype wire

// ---- testbench/gate_monitor.sv ----
// port checker for the monitor flash security gate
`default_nettype none
module gate_monitor #(parameter int BIT_CYCLES = 256) (
  // watched ports
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic cpu_rd_i,
  input wire logic cpu_fetch_i,
  input wire logic [7:0] flash_rdata_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic illegal_addr_reset_o,
  input wire logic [7:0] status_byte_o,
  input wire logic unlocked_o,
  input wire logic monitor_ready_o,
  input wire logic monitor_serial_pin_o,
  input wire logic monitor_serial_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BRK = BIT_CYCLES * 10;
  int brk_len;
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) brk_len <= 0;
    else if (monitor_serial_pin_oe_o) brk_len <= brk_len + 1;
    else brk_len <= 0;
  end
  sequence s_brk_done;
    $fell(monitor_serial_pin_oe_o);
  endsequence
  a_break_len: assert property (s_brk_done |-> brk_len == BRK)
    else $error("break length wrong");
  a_ready_late: assert property (s_brk_done |-> ##[1:3] monitor_ready_o)
    else $error("ready late after break");
  a_drive_low: assert property (monitor_serial_pin_oe_o |-> !monitor_serial_pin_o)
    else $error("break not low");
  a_rd_latency: assert property (cpu_rd_i |=> rd_valid_o)
    else $error("read valid missing");
  a_rd_open: assert property (cpu_rd_i && unlocked_o |=> rd_data_o == $past(flash_rdata_i))
    else $error("open read data wrong");
  a_rd_locked: assert property (cpu_rd_i && !unlocked_o ##1 !unlocked_o
    |-> rd_data_o == sec_gate_pkg::INVALID_READ)
    else $error("locked read leaked");
  a_fetch_trap: assert property (cpu_fetch_i && !unlocked_o ##1 !unlocked_o
    |-> illegal_addr_reset_o)
    else $error("locked fetch not trapped");
  a_fetch_open: assert property (cpu_fetch_i && unlocked_o |=> !illegal_addr_reset_o)
    else $error("open fetch trapped");
  a_status_bit: assert property (status_byte_o == {1'b0, unlocked_o, 6'h00})
    else $error("status byte wrong");
  a_unlock_hold: assert property (unlocked_o |=> unlocked_o)
    else $error("unlock lost");
endmodule : gate_monitor
bind monitor_flash_security_gate gate_monitor #(.BIT_CYCLES(BIT_CYCLES)) gate_monitor_inst (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .cpu_rd_i(cpu_rd_i), .cpu_fetch_i(cpu_fetch_i),
  .flash_rdata_i(flash_rdata_i), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
  .illegal_addr_reset_o(illegal_addr_reset_o), .status_byte_o(status_byte_o),
  .unlocked_o(unlocked_o), .monitor_ready_o(monitor_ready_o),
  .monitor_serial_pin_o(monitor_serial_pin_o), .monitor_serial_pin_oe_o(monitor_serial_pin_oe_o));
`default_nettype wire

// ---- testbench/monitor_host.sv ----
// host model driving the monitor serial pin
`default_nettype none
module monitor_host #(parameter int BIT_CYCLES = 8) (
  // clock and open-drain drive, 1 = released
  input wire logic mclk_i,
  output logic tx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial tx_o = 1'b1;
  // nrz frame, lsb first, stop high so the receiver rearms
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      tx_o = frame[i];
      repeat (BIT_CYCLES) @(negedge mclk_i);
    end
  endtask : send_byte
endmodule : monitor_host
`default_nettype wire

// ---- testbench/tb_monitor_flash_security_gate.sv ----
// self-checking bench for the monitor flash security gate
`default_nettype none
module tb_monitor_flash_security_gate;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int B = 8;
  logic mclk = 0, rst_n = 0, sys_rst = 0, we = 0, erase = 0, rd = 0, fetch = 0;
  logic [2:0] idx = 3'h0;
  logic [7:0] pdata = 8'h00, fdata = 8'h00, rdata, status;
  logic tx, oe, pin_q, rvalid, ill, unl, ready;
  wire logic pin = tx & ~oe;
  int err_count = 0, check_count = 0, oe_cnt = 0;
  initial forever #12.5 mclk = ~mclk;
  // cleared by power-on reset only, so a warm reset that sends a break shows up
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) oe_cnt <= 0;
    else if (oe === 1'b1) oe_cnt <= oe_cnt + 1;
  end
  monitor_host #(.BIT_CYCLES(B)) monitor_host_inst (.mclk_i(mclk), .tx_o(tx));
  monitor_flash_security_gate #(.BIT_CYCLES(B)) monitor_flash_security_gate_inst (
    .mclk_i(mclk), .rst_n_i(rst_n), .sys_reset_i(sys_rst), .monitor_serial_pin_i(pin),
    .monitor_serial_pin_o(pin_q), .monitor_serial_pin_oe_o(oe), .prog_we_i(we),
    .prog_idx_i(idx), .prog_data_i(pdata), .mass_erase_i(erase), .cpu_rd_i(rd),
    .cpu_fetch_i(fetch), .flash_rdata_i(fdata), .rd_data_o(rdata), .rd_valid_o(rvalid),
    .illegal_addr_reset_o(ill), .status_byte_o(status), .unlocked_o(unl),
    .monitor_ready_o(ready));
  // ****************
  // tasks
  // ****************
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up
  task automatic por(input int n);
    rst_n = 1'b0;
    repeat (n) @(negedge mclk);
    rst_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask : por
  function automatic logic [7:0] key(input int k);
    return 8'ha0 + 8'(k);
  endfunction : key
  task automatic program_all();
    for (int k = 0; k < 8; k++) begin
      we = 1'b1;
      idx = 3'(k);
      pdata = key(k);
      @(negedge mclk);
    end
    we = 1'b0;
  endtask : program_all
  // code byte k is key(k) when straight, key(7-k) when reversed, 0xff when blank
  task automatic entry(input int mode, input logic exp);
    for (int k = 0; k < 8; k++) begin
      if (k == 7) chk("early break", 8'(oe_cnt) | {7'h00, ready}, 8'h00);
      monitor_host_inst.send_byte(mode == 0 ? key(k) : mode == 1 ? key(7 - k) : 8'hff);
    end
    for (int t = 0; t < 20 * B && ready !== 1'b1; t++) @(negedge mclk);
    chk("ready", {7'h00, ready}, 8'h01);
    chk("break cycles", 8'(oe_cnt), 8'(10 * B));
    chk("unlocked", {7'h00, unl}, {7'h00, exp});
    chk("status", status, exp ? 8'h40 : 8'h00);
    fdata = 8'h5a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    fetch = 1'b1;
    chk("read data", rvalid ? rdata : 8'hee, exp ? 8'h5a : 8'h00);
    @(negedge mclk);
    fetch = 1'b0;
    chk("illegal reset", {7'h00, ill}, {7'h00, ~exp});
  endtask : entry
  task automatic t_locked();
    program_all();
    entry(1, 1'b0);
    repeat (4) @(negedge mclk);
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("relock wait", {6'h00, unl, ready}, 8'h00);
    chk("relock no break", 8'(oe_cnt), 8'(10 * B));
    $display("test locked done");
  endtask : t_locked
  task automatic t_unlock();
    por(4);
    program_all();
    entry(0, 1'b1);
    sys_rst = 1'b1;
    @(negedge mclk);
    sys_rst = 1'b0;
    repeat (4) @(negedge mclk);
    chk("warm reset", {6'h00, unl, ready}, 8'h03);
    chk("warm no break", 8'(oe_cnt), 8'(10 * B));
    por(4);
    chk("cold reset", {7'h00, unl}, 8'h00);
    $display("test unlock done");
  endtask : t_unlock
  task automatic t_erase();
    program_all();
    @(negedge mclk);
    // a program write in the erase cycle must lose
    we = 1'b1;
    idx = 3'h0;
    pdata = 8'h12;
    erase = 1'b1;
    @(negedge mclk);
    we = 1'b0;
    erase = 1'b0;
    entry(2, 1'b1);
    $display("test erase done");
  endtask : t_erase
  initial begin
    por(12);
    t_locked();
    t_unlock();
    t_erase();
    wrap_up();
  end
  // three entries take near 2200 cycles
  initial begin
    #(20000 * 25);
    err_count++;
    wrap_up();
  end
endmodule : tb_monitor_flash_security_gate
`default_nettype wire
